/* File: hw/system_tick_timer.sv */
// System tick timer: register slave, clock selection, calibration word and interrupt
`timescale 1ns/100ps
module system_tick_timer
  import tick_pkg::*;
#(
  parameter logic                        NO_REF_CLOCK = 1'b0,
  parameter logic                        CAL_SKEW     = 1'b0,
  parameter logic [tick_pkg::COUNT_W-1:0] TEN_MS_VALUE = tick_pkg::TEN_MS_START_VALUE
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_sys_rst,
  input  wire tick_pkg::reg_req_type      i_bus,
  input  wire logic                       i_ext_ref_clock,
  input  wire logic                       i_debug_halt,
  input  wire logic                       i_clock_stopped,
  output logic [tick_pkg::DATA_W-1:0]     o_rdata,
  output logic                            o_irq,
  output logic                            o_tick_request
);

  // ******************************************************************
  // Address decode
  // ******************************************************************
  wire hit_ctrl  = (i_bus.addr == CONTROL_STATUS_OFS);
  wire hit_start = (i_bus.addr == START_VALUE_OFS);
  wire hit_count = (i_bus.addr == PRESENT_COUNT_OFS);
  wire hit_cal   = (i_bus.addr == CALIBRATION_OFS);
  wire hit_ists  = (i_bus.addr == IRQ_STATUS_OFS);
  wire hit_imask = (i_bus.addr == IRQ_MASK_OFS);

  wire wr_ctrl   = i_bus.wr && hit_ctrl;
  wire wr_start  = i_bus.wr && hit_start;
  wire wr_count  = i_bus.wr && hit_count;
  wire wr_ists   = i_bus.wr && hit_ists;
  wire wr_imask  = i_bus.wr && hit_imask;
  wire rd_ctrl   = i_bus.rd && hit_ctrl;

  // ******************************************************************
  // State
  // ******************************************************************
  tick_ctrl_type             ctrl_q;
  tick_ctrl_type             ctrl_d;
  logic                      flag_q;
  logic                      flag_d;
  logic [COUNT_W-1:0]        start_q;
  logic [IRQ_W-1:0]          irq_status_q;
  logic [IRQ_W-1:0]          irq_status_d;
  logic [IRQ_W-1:0]          irq_mask_q;
  logic [DATA_W-1:0]         rdata_q;
  logic [DATA_W-1:0]         rdata_d;
  logic                      irq_q;
  logic                      tick_req_q;
  logic                      ref_meta_q;
  logic                      ref_sync_q;
  logic                      ref_prev_q;
  logic [COUNT_W-1:0]        count;
  logic                      reached_zero;

  // ******************************************************************
  // Reference clock synchroniser and edge detector
  // ******************************************************************
  // Two flops first; only the second one feeds the edge detector
  // Reset level is low like the idle pin, so no false edge follows reset
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      ref_meta_q <= i_ext_ref_clock;
      ref_sync_q <= ref_meta_q;
      ref_prev_q <= ref_sync_q;
    end
  end

  wire ref_edge = ref_sync_q && !ref_prev_q;

  // ******************************************************************
  // Count enable
  // ******************************************************************
  // Source select, then halts from the debugger and the stopped clock
  wire src_tick = ctrl_q.count_clock_select ? 1'b1 : ref_edge;
  wire step     = ctrl_q.enable && src_tick && !i_debug_halt && !i_clock_stopped;

  tick_counter #(
    .WIDTH          (COUNT_W)
  ) tick_counter_inst (
    .i_ref_clk      (i_ref_clk),
    .i_sys_rst      (i_sys_rst),
    .i_step         (step),
    .i_clear        (wr_count),
    .i_start_value  (start_q),
    .o_count        (count),
    .o_reached_zero (reached_zero)
  );

  // ******************************************************************
  // Control and flag next values
  // ******************************************************************
  // Clock select is forced to one without a reference clock
  assign ctrl_d.enable                = wr_ctrl ? i_bus.wdata[CS_ENABLE_BIT]  : ctrl_q.enable;
  assign ctrl_d.tick_exception_enable = wr_ctrl ? i_bus.wdata[CS_TICK_EXC_BIT] : ctrl_q.tick_exception_enable;
  assign ctrl_d.count_clock_select    = NO_REF_CLOCK ? 1'b1 :
                                        wr_ctrl ? i_bus.wdata[CS_CLKSEL_BIT] : ctrl_q.count_clock_select;

  // Reaching zero sets the flag and wins over a read clearing it; a count write blocks the zero event
  assign flag_d = reached_zero ? 1'b1 :
                  (rd_ctrl || wr_count) ? 1'b0 : flag_q;

  // Sticky status, write one to clear, a new event wins
  assign irq_status_d = (irq_status_q & ~(wr_ists ? i_bus.wdata[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                        | (reached_zero ? IRQ_W'(1) << IRQ_ZERO_BIT : {IRQ_W{1'b0}});

  // ******************************************************************
  // Read data
  // ******************************************************************
  wire [DATA_W-1:0] ctrl_word  = {15'h0000, flag_q, 13'h0000, ctrl_q.count_clock_select,
                                  ctrl_q.tick_exception_enable, ctrl_q.enable};
  wire [DATA_W-1:0] start_word = {8'h00, start_q};
  wire [DATA_W-1:0] count_word = {8'h00, count};
  wire [DATA_W-1:0] cal_word   = {NO_REF_CLOCK, CAL_SKEW, 6'h00, TEN_MS_VALUE};
  wire [DATA_W-1:0] ists_word  = {{(DATA_W-IRQ_W){1'b0}}, irq_status_q};
  wire [DATA_W-1:0] imask_word = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};

  // Unmapped addresses read zero
  assign rdata_d = !i_bus.rd ? RDATA_RESET :
                   hit_ctrl  ? ctrl_word  :
                   hit_start ? start_word :
                   hit_count ? count_word :
                   hit_cal   ? cal_word   :
                   hit_ists  ? ists_word  :
                   hit_imask ? imask_word : RDATA_RESET;

  // ******************************************************************
  // Registers
  // ******************************************************************
  // Control, flag, interrupt state and read port
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q       <= tick_ctrl_type'(CONTROL_RESET);
      flag_q       <= 1'b0;
      irq_status_q <= IRQ_RESET;
      irq_mask_q   <= IRQ_RESET;
      rdata_q      <= RDATA_RESET;
      irq_q        <= 1'b0;
      tick_req_q   <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      flag_q       <= flag_d;
      irq_status_q <= irq_status_d;
      irq_mask_q   <= wr_imask ? i_bus.wdata[IRQ_W-1:0] : irq_mask_q;
      rdata_q      <= rdata_d;
      irq_q        <= |(irq_status_d & irq_mask_q);
      tick_req_q   <= reached_zero && ctrl_q.tick_exception_enable;
    end
  end

  // Start value; reset value chosen only for a clean simulation
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_q <= COUNT_RESET;
    end else if (wr_start) begin
      start_q <= i_bus.wdata[COUNT_W-1:0];
    end
  end

  assign o_rdata        = rdata_q;
  assign o_irq          = irq_q;
  assign o_tick_request = tick_req_q;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  property p_count_read;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_bus.rd && hit_count) |=> (o_rdata == {8'h00, $past(count)});
  endproperty
  a_count_read: assert property (p_count_read) else $error("present count read wrong");

  property p_count_write_clears;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      wr_count |=> (count == '0) && !flag_q;
  endproperty
  a_count_write_clears: assert property (p_count_write_clears) else $error("count write did not clear");

  property p_cal_no_reference_clock;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_bus.rd && hit_cal) |=> (o_rdata[CAL_NO_REF_BIT] == NO_REF_CLOCK);
  endproperty
  a_cal_no_reference_clock: assert property (p_cal_no_reference_clock) else $error("reference clock bit wrong");

  property p_clksel_forced;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      NO_REF_CLOCK && rd_ctrl |=> o_rdata[CS_CLKSEL_BIT];
  endproperty
  a_clksel_forced: assert property (p_clksel_forced) else $error("clock select not read as one");

  property p_cal_skew;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_bus.rd && hit_cal) |=> (o_rdata[CAL_SKEW_BIT] == CAL_SKEW) && (o_rdata[29:24] == 6'h00);
  endproperty
  a_cal_skew: assert property (p_cal_skew) else $error("skew or reserved bits wrong");

  property p_cal_value;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_bus.rd && hit_cal) |=> (o_rdata[COUNT_W-1:0] == TEN_MS_VALUE);
  endproperty
  a_cal_value: assert property (p_cal_value) else $error("ten-ms value wrong");

  property p_stop_holds;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_clock_stopped && !wr_count) [*2] |=> $stable(count);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("count moved while clock stopped");

  property p_debug_holds;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_debug_halt && !wr_count) |=> (count == $past(count));
  endproperty
  a_debug_holds: assert property (p_debug_holds) else $error("count moved in debug halt");

  property p_reload;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (step && !wr_count && count == '0) |=> (count == $past(start_q));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");

  property p_zero_flags;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      reached_zero |=> flag_q && irq_status_q[IRQ_ZERO_BIT] && (o_tick_request == $past(ctrl_q.tick_exception_enable));
  endproperty
  a_zero_flags: assert property (p_zero_flags) else $error("zero event not recorded");

  property p_flag_read_clears;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (rd_ctrl && flag_q && !reached_zero) |=> o_rdata[CS_FLAG_BIT] && !flag_q;
  endproperty
  a_flag_read_clears: assert property (p_flag_read_clears) else $error("flag read did not clear");

  property p_ref_select;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!ctrl_q.count_clock_select && !ref_edge && !wr_count) |=> $stable(count);
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("count moved without reference edge");

  // ******************************************************************
  // Assertions: counting and flags
  // ******************************************************************
  property p_decrement;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (step && !wr_count && count != '0) |=> (count == $past(count) - COUNT_W'(1));
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not decrement");

  property p_clock_advances;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (ctrl_q.enable && ctrl_q.count_clock_select && !i_debug_halt && !i_clock_stopped && !wr_count
       && (count != '0 || start_q != '0)) |=> (count != $past(count));
  endproperty
  a_clock_advances: assert property (p_clock_advances) else $error("count stuck on processor clock");

  property p_flag_holds;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!reached_zero && !rd_ctrl && !wr_count) |=> $stable(flag_q);
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag changed without cause");

  property p_start_write;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      wr_start |=> (start_q == $past(i_bus.wdata[COUNT_W-1:0]));
  endproperty
  a_start_write: assert property (p_start_write) else $error("start value not stored");

  // ******************************************************************
  // Assertions: interrupt and read port
  // ******************************************************************
  property p_irq_raise;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (|(irq_status_q & irq_mask_q) && !wr_ists && !wr_imask) |=> o_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

  property p_irq_quiet;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (((irq_status_q & irq_mask_q) == '0) && !reached_zero) |=> !o_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without unmasked status");

  property p_tick_quiet;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !reached_zero |=> !o_tick_request;
  endproperty
  a_tick_quiet: assert property (p_tick_quiet) else $error("tick request without zero event");

  property p_tick_gated;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (reached_zero && !ctrl_q.tick_exception_enable) |=> !o_tick_request;
  endproperty
  a_tick_gated: assert property (p_tick_gated) else $error("tick request while disabled");

  property p_rdata_idle;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !i_bus.rd |=> (o_rdata == RDATA_RESET);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read strobe");

endmodule : system_tick_timer

/* File: hw/tick_pkg.sv */
// Constants, field layouts and carrier types of the system tick timer value registers
//
// Summary of operation
// - Present-count reads return the live 24-bit count; bits 31 to 24 read zero.
// - Any present-count write forces the count to zero and clears the reached-zero flag.
// - Calibration bit 31 is one when no reference clock is supplied, else zero.
// - Without a reference clock the clock select bit reads one and ignores writes.
// - Calibration bit 30 flags an inexact ten-ms value; bits 29 to 24 read zero.
// - Calibration bits 23 to 0 hold the ten-ms start value; zero means unknown.
// - The counter only advances while the processor clock runs; a clock stop halts it.
// - Start value and present count need no defined value after reset.
// - When enabled the counter loads, decrements, flags zero, requests exception, reloads.
// - Control bit 16 reads one if zero was reached since last read; reading clears it.
// - Control bit 2 selects the counting clock: zero reference, one processor clock.
// - While the debugger halts the processor the counter holds its value.
package tick_pkg;

  // ******************************************************************
  // Bus geometry and register offsets
  // ******************************************************************
  localparam int        ADDR_W            = 8;
  localparam int        DATA_W            = 32;
  localparam int        COUNT_W           = 24;
  localparam logic [7:0] CONTROL_STATUS_OFS = 8'h10;
  localparam logic [7:0] START_VALUE_OFS    = 8'h14;
  localparam logic [7:0] PRESENT_COUNT_OFS  = 8'h18;
  localparam logic [7:0] CALIBRATION_OFS    = 8'h1c;
  localparam logic [7:0] IRQ_STATUS_OFS     = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h24;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int CS_ENABLE_BIT   = 0;
  localparam int CS_TICK_EXC_BIT = 1;
  localparam int CS_CLKSEL_BIT   = 2;
  localparam int CS_FLAG_BIT     = 16;
  localparam int CAL_NO_REF_BIT  = 31;
  localparam int CAL_SKEW_BIT    = 30;
  localparam int IRQ_ZERO_BIT    = 0;
  localparam int IRQ_W           = 1;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [2:0]         CONTROL_RESET = 3'h4;
  localparam logic [COUNT_W-1:0] COUNT_RESET   = 24'h000000;
  localparam logic [IRQ_W-1:0]   IRQ_RESET     = 1'h0;
  localparam logic [DATA_W-1:0]  RDATA_RESET   = 32'h00000000;

  // ******************************************************************
  // Timing: ten-millisecond start value at the processor clock rate
  // ******************************************************************
  localparam longint             TEN_MS_NS          = 10_000_000;
  localparam longint             CLK_PERIOD_NS      = 10;
  localparam longint             TEN_MS_CYCLES      = TEN_MS_NS / CLK_PERIOD_NS;
  localparam logic [COUNT_W-1:0] TEN_MS_START_VALUE = COUNT_W'(TEN_MS_CYCLES - 1);

  // ******************************************************************
  // Carrier types
  // ******************************************************************
  typedef struct packed {
    logic count_clock_select;
    logic tick_exception_enable;
    logic enable;
  } tick_ctrl_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

endpackage : tick_pkg

/* File: hw/tick_counter.sv */
// Down counter with reload for the system tick timer
`timescale 1ns/100ps
module tick_counter #(
  parameter int WIDTH = 24
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_step,
  input  wire logic             i_clear,
  input  wire logic [WIDTH-1:0] i_start_value,
  output logic      [WIDTH-1:0] o_count,
  output logic                  o_reached_zero
);

  // ******************************************************************
  // Next count
  // ******************************************************************
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  wire              at_zero = (count_q == '0);
  wire              at_one  = (count_q == WIDTH'(1));

  // Clear beats a step; zero reloads, anything else decrements
  assign count_d = i_clear ? '0 :
                   !i_step ? count_q :
                   at_zero ? i_start_value : count_q - WIDTH'(1);

  // Event fires when counting from one to zero
  assign o_reached_zero = i_step && !i_clear && at_one;

  // Count register; reset value chosen only for a clean simulation
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;

endmodule : tick_counter

/* File: testbench/system_tick_timer_tb_top.sv */
// Self-checking testbench for the system tick timer value and calibration registers
`timescale 1ns/100ps
module system_tick_timer_tb_top;
  import tick_pkg::*;

  // ******************************************************************
  // Signals and design instances
  // ******************************************************************
  logic               ref_clk;
  logic               sys_rst;
  reg_req_type        bus;
  logic               ext_ref;
  logic               debug_halt;
  logic               clock_stopped;
  logic [DATA_W-1:0]  rdata_a;
  logic [DATA_W-1:0]  rdata_b;
  logic               irq_a;
  logic               tick_a;
  logic [DATA_W-1:0]  rd_a;
  logic [DATA_W-1:0]  rd_b;
  logic [COUNT_W-1:0] v1;
  int                 err_total;
  int                 comparisons;

  // Instance with a reference clock and the default calibration word
  system_tick_timer system_tick_timer_inst (
    .i_ref_clk       (ref_clk),
    .i_sys_rst       (sys_rst),
    .i_bus           (bus),
    .i_ext_ref_clock (ext_ref),
    .i_debug_halt    (debug_halt),
    .i_clock_stopped (clock_stopped),
    .o_rdata         (rdata_a),
    .o_irq           (irq_a),
    .o_tick_request  (tick_a)
  );

  // Instance without a reference clock and with no calibration known
  system_tick_timer #(
    .NO_REF_CLOCK (1'b1),
    .CAL_SKEW     (1'b1),
    .TEN_MS_VALUE (24'h000000)
  ) system_tick_timer_inst_no_reference_clock (
    .i_ref_clk       (ref_clk),
    .i_sys_rst       (sys_rst),
    .i_bus           (bus),
    .i_ext_ref_clock (ext_ref),
    .i_debug_halt    (debug_halt),
    .i_clock_stopped (clock_stopped),
    .o_rdata         (rdata_b),
    .o_irq           (),
    .o_tick_request  ()
  );

  // Processor clock, 100 MHz
  always #5 ref_clk = ~ref_clk;

  // ******************************************************************
  // Bus tasks and comparisons
  // ******************************************************************
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  // One-cycle write strobe beside address and data
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : bus_write

  // One-cycle read strobe; data stand only in the following cycle
  task automatic bus_read(input logic [7:0] a);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    rd_a = rdata_a;
    rd_b = rdata_b;
  endtask : bus_read

  task automatic read_check(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus_read(a);
    check_word(name, exp, rd_a);
  endtask : read_check

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  // Bounded wait for the tick exception pulse
  task automatic wait_tick();
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      #1;
      if (tick_a === 1'b1) break;
    end
    if (i == 60) begin
      err_total++;
      $display("CHECK FAILED tick_request expected 1 seen timeout");
      tally_and_finish();
    end
  endtask : wait_tick

  task automatic tally_and_finish();
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    ref_clk       = 1'b0;
    sys_rst       = 1'b1;
    bus           = '0;
    ext_ref       = 1'b0;
    debug_halt    = 1'b0;
    clock_stopped = 1'b0;
    err_total     = 0;
    comparisons   = 0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Control reset value of the first instance, calibration words of both instances
    read_check("control reset", CONTROL_STATUS_OFS, 32'h00000004);
    read_check("calibration", CALIBRATION_OFS, {8'h00, TEN_MS_START_VALUE});
    check_word("calibration no_reference_clock", 32'hc0000000, rd_b);
    bus_write(CALIBRATION_OFS, 32'hffffffff);
    read_check("calibration after write", CALIBRATION_OFS, {8'h00, TEN_MS_START_VALUE});
    read_check("unmapped read", 8'h40, 32'h00000000);
    // Initialise in order: start value, clear count, then control
    bus_write(START_VALUE_OFS, 32'h00000005);
    bus_write(PRESENT_COUNT_OFS, 32'h00000000);
    bus_write(IRQ_MASK_OFS, 32'h00000001);
    bus_write(CONTROL_STATUS_OFS, 32'h00000007);
    wait_tick();
    idle(1);
    check_bit("irq unmasked", 1'b1, irq_a);
    read_check("irq status", IRQ_STATUS_OFS, 32'h00000001);
    // Live count: two reads two cycles apart on a period of six
    bus_read(PRESENT_COUNT_OFS);
    check_word("count reserved", 32'h00000000, rd_a & 32'hff000000);
    v1 = rd_a[COUNT_W-1:0];
    read_check("count live", PRESENT_COUNT_OFS, (v1 >= 2) ? v1 - 2 : v1 + 4);
    bus_write(CONTROL_STATUS_OFS, 32'h00000006);
    read_check("flag set", CONTROL_STATUS_OFS, 32'h00010006);
    read_check("flag cleared by read", CONTROL_STATUS_OFS, 32'h00000006);
    // Interrupt clear and masking
    bus_write(IRQ_STATUS_OFS, 32'h00000001);
    idle(2);
    check_bit("irq after clear", 1'b0, irq_a);
    bus_write(IRQ_MASK_OFS, 32'h00000000);
    bus_write(CONTROL_STATUS_OFS, 32'h00000007);
    wait_tick();
    bus_write(CONTROL_STATUS_OFS, 32'h00000006);
    idle(2);
    check_bit("irq masked", 1'b0, irq_a);
    read_check("irq status masked", IRQ_STATUS_OFS, 32'h00000001);
    bus_write(IRQ_MASK_OFS, 32'h00000001);
    idle(2);
    check_bit("irq mask opened", 1'b1, irq_a);
    bus_write(IRQ_STATUS_OFS, 32'h00000001);
    // Any write clears the count and the reached-zero flag
    bus_write(PRESENT_COUNT_OFS, 32'hffffffff);
    read_check("count after write", PRESENT_COUNT_OFS, 32'h00000000);
    read_check("flag after count write", CONTROL_STATUS_OFS, 32'h00000006);
    // Debug halt and clock stop freeze the running count
    bus_write(CONTROL_STATUS_OFS, 32'h00000007);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      if (k == 0) debug_halt <= 1'b1;
      else clock_stopped <= 1'b1;
      idle(2);
      read_check("count frozen", PRESENT_COUNT_OFS, (k == 0) ? 32'h00000005 : 32'h00000003);
      idle(3);
      read_check("count held", PRESENT_COUNT_OFS, (k == 0) ? 32'h00000005 : 32'h00000003);
      @(posedge ref_clk);
      debug_halt    <= 1'b0;
      clock_stopped <= 1'b0;
      idle(1);
    end
    // External reference clock: count only on reference edges
    bus_write(CONTROL_STATUS_OFS, 32'h00000000);
    bus_write(START_VALUE_OFS, 32'h00000064);
    bus_write(PRESENT_COUNT_OFS, 32'h00000000);
    bus_write(CONTROL_STATUS_OFS, 32'h00000001);
    idle(6);
    read_check("count no ref edge", PRESENT_COUNT_OFS, 32'h00000000);
    read_check("clock select ext", CONTROL_STATUS_OFS, 32'h00000001);
    check_word("clock select no_reference_clock", 32'h00000005, rd_b);
    repeat (3) begin
      @(posedge ref_clk);
      ext_ref <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_ref <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    idle(6);
    read_check("count on ref edges", PRESENT_COUNT_OFS, 32'h00000062);
    tally_and_finish();
  end

endmodule : system_tick_timer_tb_top
